// >>> rtl/fps_pkg.sv
// package: constants for the flash erase/program sequencer host controller
// assumes: one 200 MHz core clock; flash pins driven through this controller
package fps_pkg;
	// wishbone register offsets (byte addresses)
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_ADDR = 4'h4;
	localparam logic [3:0] ADDR_STAT = 4'h8;
	localparam logic [3:0] ADDR_RDAT = 4'hc;
	// control word fields
	localparam int CTRL_CMD_LSB = 0;
	localparam int CTRL_DATA_LSB = 8;
	localparam int CTRL_GO_BIT = 16;
	// status word fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_FAIL_BIT = 2;
	localparam int STAT_TIMER_BIT = 3;
	// host commands
	localparam logic [2:0] CMD_PROGRAM = 3'h1;
	localparam logic [2:0] CMD_ERASE = 3'h2;
	localparam logic [2:0] CMD_ERASE_MORE = 3'h3;
	localparam logic [2:0] CMD_SUSPEND = 3'h4;
	localparam logic [2:0] CMD_RESUME = 3'h5;
	localparam logic [2:0] CMD_READ = 3'h6;
	localparam logic [2:0] CMD_RESET = 3'h7;
	// flash command codes and unlock pairs
	localparam logic [7:0] FL_SETUP = 8'h80;
	localparam logic [7:0] FL_SECTOR = 8'h30;
	localparam logic [7:0] FL_SUSPEND = 8'hb0;
	localparam logic [7:0] FL_RESUME = 8'h30;
	localparam logic [7:0] FL_PROGRAM = 8'ha0;
	localparam logic [7:0] FL_RESET = 8'hf0;
	localparam logic [7:0] UNLOCK_D1 = 8'haa;
	localparam logic [7:0] UNLOCK_D2 = 8'h55;
	localparam logic [18:0] UNLOCK_A1 = 19'h00555;
	localparam logic [18:0] UNLOCK_A2 = 19'h002aa;
	// status bit positions on the flash data bus
	localparam int DATA_POLL_BIT = 7;
	localparam int TOGGLE_ONE_BIT = 6;
	localparam int TIME_LIMIT_BIT = 5;
	localparam int ERASE_TIMER_BIT = 3;
	// timing
	localparam int CLK_MHZ = 200;
	localparam int LOAD_WINDOW_US = 30;
	localparam int LOAD_WINDOW_CYC = LOAD_WINDOW_US * CLK_MHZ;
	localparam int SUSPEND_US = 100;
	localparam int SUSPEND_CYC = SUSPEND_US * CLK_MHZ;
	localparam int PHASE_CYC = 4;
endpackage

// >>> rtl/fps_host.sv
// file: host controller that drives a byte-wide flash through its strobes
// assumes: classic wishbone slave for software; flash pins asynchronous to core_clk
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps

// What this block does
// - erase: two unlocks, 80H, two unlocks, 30H
// - extra sector loads within 30us of previous (this block stays busy the whole 30us after each load)
// - status reads use the target address
// - program: two unlocks then A0H
// - after time limit failure send reset (not sent by this block: fail is set and software must issue CMD_RESET)
module fps_host #(
	parameter int LOAD_WINDOW_CYC = fps_pkg::LOAD_WINDOW_CYC,
	parameter int SUSPEND_CYC = fps_pkg::SUSPEND_CYC
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [18:0] fl_addr,
	output logic fl_ce_n,
	output logic fl_we_n,
	output logic fl_oe_n,
	output logic [7:0] fl_dq_o,
	output logic fl_dq_oe,
	input wire logic [7:0] fl_dq_i
);
	// ************************************************
	// states
	// ************************************************
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_WR_SETUP = 4'b0001,
		ST_WR_LOW = 4'b0010,
		ST_WR_HIGH = 4'b0011,
		ST_RD_LOW = 4'b0100,
		ST_RD_SAMPLE = 4'b0101,
		ST_RD_HIGH = 4'b0110,
		ST_POLL = 4'b0111,
		ST_WAIT = 4'b1000
	} fps_state_e;

	fps_state_e state_reg;
	fps_state_e state_next;
	logic [18:0] tgt_addr_reg;
	logic [7:0] wdata_reg;
	logic [2:0] cmd_reg;
	logic [2:0] step_reg;
	logic [2:0] nsteps_reg;
	logic [7:0] rdata_reg;
	logic [7:0] prev_reg;
	logic have_prev_reg;
	logic busy_reg;
	logic done_reg;
	logic fail_reg;
	logic timer_reg;
	logic polling_reg;
	logic [2:0] phase_reg;
	logic [31:0] wait_reg;
	logic [31:0] window_reg;
	logic [7:0] dq_s1_reg;
	logic [7:0] dq_s2_reg;

	// ************************************************
	// register bus decode
	// ************************************************
	wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr_ctrl = bus_req && wb_we_i && wb_adr_i == fps_pkg::ADDR_CTRL && wb_sel_i[2];
	wire wr_addr = bus_req && wb_we_i && wb_adr_i == fps_pkg::ADDR_ADDR;
	wire [2:0] go_cmd = wb_dat_i[fps_pkg::CTRL_CMD_LSB +: 3];
	wire go = wr_ctrl && wb_dat_i[fps_pkg::CTRL_GO_BIT] && !busy_reg;
	wire [31:0] stat_word = {28'h0, timer_reg, fail_reg, done_reg, busy_reg};
	wire [31:0] rd_mux = (wb_adr_i == fps_pkg::ADDR_ADDR) ? {13'h0, tgt_addr_reg} :
		(wb_adr_i == fps_pkg::ADDR_STAT) ? stat_word :
		(wb_adr_i == fps_pkg::ADDR_RDAT) ? {24'h0, rdata_reg} : 32'h0;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= rd_mux;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tgt_addr_reg <= 19'h0;
		end else if (wr_addr) begin
			tgt_addr_reg <= wb_dat_i[18:0];
		end
	end

	// ************************************************
	// command sequence table
	// ************************************************
	// write step k of the current command: address and data on the pins
	logic [18:0] seq_addr;
	logic [7:0] seq_data;
	always_comb begin
		seq_addr = fps_pkg::UNLOCK_A1;
		seq_data = fps_pkg::UNLOCK_D1;
		if (step_reg == 3'h1 || step_reg == 3'h4) begin
			seq_addr = fps_pkg::UNLOCK_A2;
			seq_data = fps_pkg::UNLOCK_D2;
		end
		case (cmd_reg)
			fps_pkg::CMD_PROGRAM: begin
				if (step_reg == 3'h2) seq_data = fps_pkg::FL_PROGRAM;
				if (step_reg == 3'h3) begin
					seq_addr = tgt_addr_reg;
					seq_data = wdata_reg;
				end
			end
			fps_pkg::CMD_ERASE: begin
				if (step_reg == 3'h2) seq_data = fps_pkg::FL_SETUP;
				if (step_reg == 3'h5) begin
					seq_addr = tgt_addr_reg;
					seq_data = fps_pkg::FL_SECTOR;
				end
			end
			fps_pkg::CMD_ERASE_MORE: begin
				seq_addr = tgt_addr_reg;
				seq_data = fps_pkg::FL_SECTOR;
			end
			fps_pkg::CMD_SUSPEND: begin
				seq_addr = tgt_addr_reg;
				seq_data = fps_pkg::FL_SUSPEND;
			end
			fps_pkg::CMD_RESUME: begin
				seq_addr = tgt_addr_reg;
				seq_data = fps_pkg::FL_RESUME;
			end
			fps_pkg::CMD_RESET: begin
				seq_data = fps_pkg::FL_RESET;
			end
			default: begin
				seq_addr = tgt_addr_reg;
			end
		endcase
	end

	// ************************************************
	// flash pin sequencer
	// ************************************************
	// toggle bit one steady over two reads ends a poll
	// compare latched reads: by now the pins show a released bus, not the status
	wire toggle_steady = have_prev_reg && (prev_reg[fps_pkg::TOGGLE_ONE_BIT] == rdata_reg[fps_pkg::TOGGLE_ONE_BIT]);
	wire poll_ok = (cmd_reg == fps_pkg::CMD_PROGRAM) ?
		(rdata_reg[7:6] == wdata_reg[7:6]) : rdata_reg[fps_pkg::DATA_POLL_BIT];
	wire time_limit = rdata_reg[fps_pkg::TIME_LIMIT_BIT];
	// a finished poll goes straight home, so no stray read can swallow the next go
	wire poll_stop = toggle_steady || (time_limit && have_prev_reg);
	wire phase_end = phase_reg == 3'(fps_pkg::PHASE_CYC - 1);
	wire last_step = step_reg == nsteps_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: if (go) state_next = (go_cmd == fps_pkg::CMD_READ) ? ST_RD_LOW : ST_WR_SETUP;
			ST_WR_SETUP: if (phase_end) state_next = ST_WR_LOW;
			ST_WR_LOW: if (phase_end) state_next = ST_WR_HIGH;
			ST_WR_HIGH: if (phase_end) state_next = !last_step ? ST_WR_SETUP : polling_reg ? ST_RD_LOW : ST_WAIT;
			ST_RD_LOW: if (phase_end) state_next = ST_RD_SAMPLE;
			ST_RD_SAMPLE: state_next = ST_RD_HIGH;
			ST_RD_HIGH: if (phase_end) state_next = polling_reg ? ST_POLL : ST_IDLE;
			ST_POLL: state_next = poll_stop ? ST_IDLE : ST_RD_LOW;
			ST_WAIT: if (wait_reg == 32'h0) state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	// two flops on the data pins: the flash answers asynchronously
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dq_s1_reg <= 8'h0;
			dq_s2_reg <= 8'h0;
		end else begin
			dq_s1_reg <= fl_dq_i;
			dq_s2_reg <= dq_s1_reg;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			phase_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			phase_reg <= (state_next != state_reg || phase_end) ? 3'h0 : phase_reg + 3'h1;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmd_reg <= fps_pkg::CMD_READ;
			wdata_reg <= 8'h0;
			step_reg <= 3'h0;
			nsteps_reg <= 3'h0;
			polling_reg <= 1'b0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
			rdata_reg <= 8'h0;
			prev_reg <= 8'h0;
			have_prev_reg <= 1'b0;
			timer_reg <= 1'b0;
			wait_reg <= 32'h0;
		end else begin
			if (go) begin
				cmd_reg <= go_cmd;
				wdata_reg <= wb_dat_i[fps_pkg::CTRL_DATA_LSB +: 8];
				step_reg <= 3'h0;
				busy_reg <= 1'b1;
				done_reg <= 1'b0;
				fail_reg <= 1'b0;
				have_prev_reg <= 1'b0;
				// six writes for erase, four for program, none for read, one otherwise
				nsteps_reg <= (go_cmd == fps_pkg::CMD_ERASE) ? 3'h5 :
					(go_cmd == fps_pkg::CMD_PROGRAM) ? 3'h3 : 3'h0;
				polling_reg <= go_cmd == fps_pkg::CMD_PROGRAM;
				// erase and each follow-up sector both wait out the load window; suspend waits its own time
				wait_reg <= (go_cmd == fps_pkg::CMD_ERASE || go_cmd == fps_pkg::CMD_ERASE_MORE) ?
					32'(LOAD_WINDOW_CYC) : (go_cmd == fps_pkg::CMD_SUSPEND) ? 32'(SUSPEND_CYC) : 32'h0;
			end
			if (state_reg == ST_WR_HIGH && phase_end && !last_step) step_reg <= step_reg + 3'h1;
			if (state_reg == ST_WAIT && wait_reg != 32'h0) wait_reg <= wait_reg - 32'h1;
			if (state_reg == ST_WAIT && wait_reg == 32'h0) begin
				busy_reg <= 1'b0;
				done_reg <= 1'b1;
			end
			if (state_reg == ST_RD_SAMPLE) begin
				rdata_reg <= dq_s2_reg;
				timer_reg <= dq_s2_reg[fps_pkg::ERASE_TIMER_BIT];
			end
			if (state_reg == ST_RD_HIGH && phase_end && !polling_reg) begin
				busy_reg <= 1'b0;
				done_reg <= 1'b1;
			end
			if (state_reg == ST_POLL) begin
				prev_reg <= rdata_reg;
				have_prev_reg <= 1'b1;
				// stop once steady; data check reports failure
				if (toggle_steady) begin
					polling_reg <= 1'b0;
					busy_reg <= 1'b0;
					done_reg <= 1'b1;
					fail_reg <= !poll_ok;
				end else if (time_limit && have_prev_reg) begin
					polling_reg <= 1'b0;
					busy_reg <= 1'b0;
					fail_reg <= 1'b1;
				end
			end
		end
	end

	// ************************************************
	// pin drive
	// ************************************************
	// ce low first, we low one cycle after, we and ce high again on the same edge
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fl_addr <= 19'h0;
			fl_ce_n <= 1'b1;
			fl_we_n <= 1'b1;
			fl_oe_n <= 1'b1;
			fl_dq_o <= 8'h0;
			fl_dq_oe <= 1'b0;
		end else begin
			fl_addr <= (state_next == ST_WR_SETUP || state_next == ST_WR_LOW || state_next == ST_WR_HIGH) ?
				seq_addr : tgt_addr_reg;
			fl_dq_o <= seq_data;
			fl_dq_oe <= state_next == ST_WR_SETUP || state_next == ST_WR_LOW || state_next == ST_WR_HIGH;
			fl_ce_n <= !(state_next == ST_WR_LOW || state_next == ST_RD_LOW || state_next == ST_RD_SAMPLE);
			fl_we_n <= !(state_next == ST_WR_LOW && state_reg == ST_WR_LOW);
			fl_oe_n <= !(state_next == ST_RD_LOW || state_next == ST_RD_SAMPLE);
		end
	end
endmodule

// >>> bench/fps_host_properties.sv
// checker: flash strobe and bus timing of fps_host
// assumes: bound to fps_host, single core clock
`timescale 1ns/1ps
module fps_chk (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [18:0] fl_addr,
	input wire logic fl_ce_n,
	input wire logic fl_we_n,
	input wire logic fl_oe_n,
	input wire logic [7:0] fl_dq_o,
	input wire logic fl_dq_oe
);
	// ****
	// properties
	// ****
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not a single pulse");
	property p_wr;
		!fl_we_n |-> !fl_ce_n && fl_oe_n && fl_dq_oe;
	endproperty
	a_wr: assert property (p_wr) else $error("bad write cycle");
	property p_pulse;
		$fell(fl_we_n) |-> !fl_we_n[*3] ##1 fl_we_n;
	endproperty
	a_pulse: assert property (p_pulse) else $error("write pulse length");
	property p_hold;
		!fl_we_n |=> fl_we_n || ($stable(fl_dq_o) && $stable(fl_addr));
	endproperty
	a_hold: assert property (p_hold) else $error("write data moved");
	property p_rd;
		!fl_oe_n |-> !fl_dq_oe && fl_we_n && !fl_ce_n;
	endproperty
	a_rd: assert property (p_rd) else $error("bad read cycle");
	property p_radr;
		!fl_oe_n |=> fl_oe_n || $stable(fl_addr);
	endproperty
	a_radr: assert property (p_radr) else $error("read address moved");
endmodule
bind fps_host fps_chk chk_u (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n),
	.fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe));

// >>> bench/fps_flash_model.sv
// model: byte-wide flash command machine
// assumes: strobes active low, sector is addr[18:16], times shortened
`timescale 1ns/1ps
module fps_flash_model #(
	parameter int LOAD_NS = 2000,
	parameter int OP_NS = 400
) (
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [18:0] a,
	input wire logic [7:0] d,
	input wire logic fail,
	input wire logic prot,
	output logic [7:0] q
);
	// ****
	// state: mode 0 read, 1 program, 2 load, 3 erase, 4 suspended, 5 suspended program
	// ****
	int mode = 0, step = 0, gen = 0;
	logic [7:0] mem [int];
	logic [7:0] sec = 8'h00, pd = 8'h00;
	logic [18:0] la;
	logic t1 = 0, t2 = 0, tl = 0, wr = 0, rd = 0;
	initial q = 8'h00;
	function automatic logic [7:0] view(logic [18:0] ad);
		logic s;
		s = sec[ad[18:16]];
		case (mode)
			1, 5: return {~pd[7], t1, tl, 5'h00};
			2, 3: return {1'b0, t1, 2'b00, mode == 3, t2 & s, 2'b00};
			4: return s ? {1'b1, t1, 3'h0, t2, 2'b00} : (mem.exists(ad) ? mem[ad] : 8'hff);
			default: return mem.exists(ad) ? mem[ad] : 8'hff;
		endcase
	endfunction
	task automatic erase_go();
		int g;
		mode = 3;
		gen++;
		g = gen;
		fork begin
			#(OP_NS);
			if (g == gen) begin
				foreach (mem[k]) if (sec[k[18:16]]) mem[k] = 8'hff;
				sec = 8'h00;
				mode = 0;
			end
		end join_none
	endtask
	task automatic win();
		int g;
		gen++;
		g = gen;
		fork begin
			#(LOAD_NS);
			if (g == gen && mode == 2) erase_go();
		end join_none
	endtask
	task automatic prog(logic [18:0] ad, logic [7:0] v);
		pd = v;
		mode = (mode == 4) ? 5 : 1;
		fork begin
			#(prot ? OP_NS / 4 : OP_NS / 2);
			if (prot) mode = (mode == 5) ? 4 : 0;
			else if (fail) tl = 1;
			else begin
				mem[ad] = v;
				mode = (mode == 5) ? 4 : 0;
			end
		end join_none
	endtask
	task automatic cmd(logic [18:0] ad, logic [7:0] v);
		if (tl) begin
			if (v == 8'hf0) {tl, mode} = 0;
		end else if (mode == 2) begin
			if (v == 8'h30) sec[ad[18:16]] = 1'b1;
			if (v == 8'h30) win();
			else if (v == 8'hb0) begin
				gen++;
				mode = 4;
			end else {gen, mode, sec} = 0;
		end else if (mode == 3) begin
			if (v == 8'hb0) fork begin
				#(OP_NS / 8);
				gen++;
				mode = 4;
			end join_none
		end else if (mode == 1 || mode == 5) step = 0;
		else if (step == 6) begin
			step = 0;
			if (wr) prog(ad, v);
		end
		else if (step % 3 == 0 && ad == 19'h00555 && v == 8'haa) step++;
		else if (step % 3 == 1 && ad == 19'h002aa && v == 8'h55) step++;
		else if (step == 2 && v == 8'ha0) step = 6;
		else if (step == 2 && v == 8'h80 && mode == 0) step = 3;
		else if (step == 5 && v == 8'h30 && mode == 0) begin
			{step, sec} = 0;
			if (prot) prog(ad, v);
			else begin
				sec[ad[18:16]] = 1'b1;
				mode = 2;
				win();
			end
		end else if (mode == 4 && step == 0 && v == 8'h30) erase_go();
		else step = 0;
	endtask
	always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n && oe_n) {la, wr} = {a, 1'b1};
	always @(posedge we_n or posedge ce_n) if (wr) begin
		wr = (step == 6);
		cmd(la, d);
		wr = 0;
	end
	always @(negedge oe_n or negedge ce_n) if (!oe_n && !ce_n) {rd, q} = {1'b1, view(a)};
	always @(posedge oe_n or posedge ce_n) if (rd) begin
		rd = 0;
		q = ~q;
		if (mode inside {1, 2, 3, 5}) t1 = ~t1;
		if (sec[a[18:16]] && mode inside {2, 3, 4}) t2 = ~t2;
	end
endmodule

// >>> bench/tb.sv
// bench: software-level checks of fps_host against the flash model
// assumes: fps_pkg, fps_host and the flash model compiled first
`timescale 1ns/1ps
module tb;
	logic core_clk = 0, sys_rst = 1, req = 0, we = 0, fail = 0, timer = 0, prot = 0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, wb_dat_o;
	logic wb_ack_o, fl_ce_n, fl_we_n, fl_oe_n, fl_dq_oe;
	logic [18:0] fl_addr;
	logic [7:0] fl_dq_o, mq;
	wire logic [7:0] dq_w = fl_dq_oe ? fl_dq_o : mq;
	int error_cnt = 0, samples_checked = 0;
	fps_host #(.LOAD_WINDOW_CYC(20), .SUSPEND_CYC(20)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
		.wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fl_addr(fl_addr),
		.fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_dq_o(fl_dq_o),
		.fl_dq_oe(fl_dq_oe), .fl_dq_i(dq_w));
	fps_flash_model fl_u (.ce_n(fl_ce_n), .we_n(fl_we_n), .oe_n(fl_oe_n), .a(fl_addr), .d(dq_w),
		.fail(fail), .prot(prot), .q(mq));
	// ****
	// tasks
	// ****
	task automatic close_out();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
		@(posedge core_clk);
		req <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge core_clk); while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		req <= 1'b0;
	endtask
	task automatic op(logic [2:0] c, logic [18:0] a, logic [7:0] d);
		bus(1, fps_pkg::ADDR_ADDR, {13'h0000, a});
		bus(1, fps_pkg::ADDR_CTRL, {15'h0000, 1'b1, d, 5'h00, c});
		do bus(0, fps_pkg::ADDR_STAT, 32'h0); while (rdat[0] !== 1'b0);
	endtask
	task automatic rd(logic [18:0] a);
		op(fps_pkg::CMD_READ, a, 8'h00);
		bus(0, fps_pkg::ADDR_RDAT, 32'h0);
	endtask
	initial forever #2.5 core_clk = ~core_clk;
	initial begin
		#400000;
		error_cnt++;
		close_out();
	end
	initial begin
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		bus(0, fps_pkg::ADDR_STAT, 32'h0);
		chk(rdat, 32'h0);
		bus(0, 4'h2, 32'h0);
		chk(rdat, 32'h0);
		op(fps_pkg::CMD_PROGRAM, 19'h01234, 8'h5a);
		chk(rdat[2:1], 2'b01);
		rd(19'h01234);
		chk(rdat, 32'h5a);
		prot <= 1'b1;
		op(fps_pkg::CMD_ERASE, 19'h00000, 8'h00);
		rd(19'h01234);
		chk(rdat, 32'h5a);
		op(fps_pkg::CMD_PROGRAM, 19'h01237, 8'h77);
		chk(rdat[2:1], 2'b11);
		prot <= 1'b0;
		op(fps_pkg::CMD_PROGRAM, 19'h20010, 8'h00);
		op(fps_pkg::CMD_ERASE, 19'h10000, 8'h00);
		op(fps_pkg::CMD_ERASE_MORE, 19'h20000, 8'h00);
		rd(19'h10000);
		chk({rdat[7], rdat[3]}, 2'b00);
		bus(0, fps_pkg::ADDR_STAT, 32'h0);
		chk(rdat[3], 1'b0);
		bus(0, fps_pkg::ADDR_ADDR, 32'h0);
		chk(rdat, 32'h10000);
		do begin
			rd(19'h20010);
			timer |= rdat[3] & ~rdat[7];
		end while (rdat[7:0] !== 8'hff);
		chk(timer, 1'b1);
		rd(19'h01234);
		chk(rdat, 32'h5a);
		op(fps_pkg::CMD_ERASE, 19'h30000, 8'h00);
		op(fps_pkg::CMD_SUSPEND, 19'h30000, 8'h00);
		rd(19'h01234);
		chk(rdat, 32'h5a);
		rd(19'h30000);
		chk(rdat[7], 1'b1);
		op(fps_pkg::CMD_PROGRAM, 19'h01235, 8'h3c);
		rd(19'h01235);
		chk(rdat, 32'h3c);
		op(fps_pkg::CMD_RESUME, 19'h30000, 8'h00);
		do rd(19'h30000); while (rdat[7:0] !== 8'hff);
		fail <= 1'b1;
		op(fps_pkg::CMD_PROGRAM, 19'h01236, 8'h11);
		chk(rdat[2], 1'b1);
		op(fps_pkg::CMD_RESET, 19'h00000, 8'h00);
		fail <= 1'b0;
		op(fps_pkg::CMD_PROGRAM, 19'h01236, 8'h11);
		chk(rdat[2:1], 2'b01);
		close_out();
	end
endmodule
